// file: design/etc_top.sv
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// [R1] absolute exposure is written in microseconds, one microsecond per step
// [R2] writing absolute exposure recomputes the multiplier for the current step unit
// [R3] software should request whole multiples of the step unit
// [R4] unreachable absolute values are replaced by the nearest achievable duration
// [R5] writing multiplier or step updates the readable absolute exposure
// [R6] legacy mode has no acquisition-start trigger stage
// [R7] in legacy mode the per-frame trigger behaves as standard frame-start
// [R8] acquisition control comes up in legacy mode after reset
// [R9] continuous run with both triggers off generates all triggers internally
// [R10] free run paces frames at the target frame period unless slower
// [R11] with rate control disabled frames run as fast as allowed
// [R12] acquisition-start trigger off means internal acquisition-start triggers
// [R13] frame-start trigger on needs one external trigger per frame
// [R14] selected edge on input pin one starts a frame acquisition
// [R15] each acquired frame is forwarded downstream after exposure and readout
// [R16] exposure duration is multiplier times step unit
// [R17] multiplier writes outside 1 to 4095 are ignored
// [R18] frame triggers count only while waiting for a frame trigger
// [R19] trigger pin is synchronised; one event per qualifying edge
// [R20] exposure is timed in clock ticks from the accepted frame trigger
module etc_top
  import etc_pkg::*;
#(
  parameter int unsigned READOUT_CYCLES = READOUT_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic              trig_pin_in,
  output logic                   exposing_out,
  output logic                   frame_valid_out,
  output logic                   wait_frame_out
);

  function automatic logic [CNT_W-1:0] us_to_cycles(input logic [ABS_W-1:0] us);
    us_to_cycles = CNT_W'({8'h00, us} * CNT_W'(CYC_PER_US));
  endfunction

  // ---------------------------------------------------------------- registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [STEP_W-1:0] step_q;
  logic [MULT_W-1:0] mult_q;
  logic [DATA_W-1:0] period_q;
  logic [DATA_W-1:0] frames_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              soft_acq_q;
  logic              soft_frame_q;
  logic              div_wait_q;

  etc_div_if div_bus ();

  etc_expo_div u_div (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .div       (div_bus)
  );

  wire wr_ctrl   = wr_en_in && addr_in == OFS_CTRL;
  wire wr_mult   = wr_en_in && addr_in == OFS_MULT;
  wire wr_step   = wr_en_in && addr_in == OFS_STEP;
  wire wr_abs    = wr_en_in && addr_in == OFS_ABS;
  wire wr_period = wr_en_in && addr_in == OFS_PERIOD;
  wire wr_soft   = wr_en_in && addr_in == OFS_SOFT_TRIG;

  // multiplier range check before accepting
  wire mult_ok = wr_data_in[MULT_W-1:0] >= MULT_MIN && wr_data_in[DATA_W-1:MULT_W] == '0; // R17
  wire step_ok = wr_data_in[STEP_W-1:0] != '0 && wr_data_in[DATA_W-1:STEP_W] == '0;

  // absolute view is always the product, so it tracks raw writes for free
  wire [ABS_W-1:0] abs_val = ABS_W'({{STEP_W{1'b0}}, mult_q} * {{MULT_W{1'b0}}, step_q}); // R16 R5 R4

  // divider started on an absolute write; result rounds to nearest step
  assign div_bus.start    = wr_abs; // R1 R2
  assign div_bus.dividend = wr_data_in; // R1
  assign div_bus.divisor  = step_q;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q     <= CTRL_RST; // R8
      step_q     <= STEP_RST;
      mult_q     <= MULT_RST;
      period_q   <= PERIOD_RST;
      div_wait_q <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= wr_data_in[CTRL_W-1:0];
      if (wr_step && step_ok)
        step_q <= wr_data_in[STEP_W-1:0];
      if (wr_period)
        period_q <= wr_data_in;
      if (wr_abs)
        div_wait_q <= 1'b1;
      else if (wr_mult || wr_step)
        div_wait_q <= 1'b0;
      else if (div_bus.done)
        div_wait_q <= 1'b0;
      // a later raw write overrides a pending absolute conversion
      if (wr_mult && mult_ok)
        mult_q <= wr_data_in[MULT_W-1:0]; // R17 R5
      else if (div_bus.done && div_wait_q)
        mult_q <= div_bus.mult; // R2 R4
    end
  end

  // --------------------------------------------------------- trigger pin sync
  logic [2:0] sync_q;
  logic       pin_lvl_q;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_q    <= 3'h0;
      pin_lvl_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], trig_pin_in}; // R19
      if (sync_q[1] == sync_q[2])
        pin_lvl_q <= sync_q[2]; // R19
    end
  end

  wire pin_changed = sync_q[1] == sync_q[2] && sync_q[2] != pin_lvl_q;
  wire pin_edge    = pin_changed && (sync_q[2] != ctrl_q[CTRL_FALLING]); // R14 R19

  // --------------------------------------------------------- trigger selection
  wire legacy    = ctrl_q[CTRL_LEGACY];
  wire acq_on    = ctrl_q[CTRL_ACQ_ON] && !legacy; // R6
  wire frame_on  = ctrl_q[CTRL_FRAME_ON]; // R7
  wire rate_en   = ctrl_q[CTRL_RATE_EN];
  wire run       = ctrl_q[CTRL_RUN];
  wire from_pin  = !ctrl_q[CTRL_ORIGIN];

  wire soft_acq_hit   = wr_soft && wr_data_in[SOFT_ACQ];
  wire soft_frame_hit = wr_soft && wr_data_in[SOFT_FRAME];

  // external frame trigger source: pin edge or software command
  wire ext_frame = from_pin ? pin_edge : soft_frame_hit; // R14 R13

  etc_state_t        state_q;
  etc_state_t        state_d;
  logic [CNT_W-1:0]  tick_q;
  logic [CNT_W-1:0]  pace_q;
  logic              exposing_q;
  logic              frame_valid_q;
  logic              wait_frame_q;

  // frame pacing counts from each frame start; saturates so a long idle never wraps
  wire [CNT_W-1:0] period_cyc = us_to_cycles(period_q);
  wire             pace_ok    = !rate_en || pace_q >= period_cyc; // R10 R11
  wire [CNT_W-1:0] expo_cyc   = us_to_cycles(abs_val); // R20 R16

  wire acq_go   = !acq_on || soft_acq_q; // R12
  wire frame_go = frame_on ? ext_frame : pace_ok; // R9 R13 R10
  wire tick_end = tick_q <= CNT_W'(1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ETC_IDLE: begin
        if (run)
          state_d = legacy ? ETC_WAIT_FRAME : ETC_WAIT_ACQ; // R6
      end
      ETC_WAIT_ACQ: begin
        if (!run)
          state_d = ETC_IDLE;
        else if (acq_go)
          state_d = ETC_WAIT_FRAME; // R12 R9
      end
      ETC_WAIT_FRAME: begin
        if (!run)
          state_d = ETC_IDLE;
        else if (frame_go)
          state_d = ETC_EXPOSE; // R18 R13
      end
      ETC_EXPOSE: begin
        if (tick_end)
          state_d = ETC_READOUT; // R20
      end
      ETC_READOUT: begin
        if (tick_end)
          state_d = ETC_WAIT_FRAME; // R15
      end
      // three spare codes of the state word fall back to idle
      default: state_d = ETC_IDLE;
    endcase
  end

  wire frame_start = state_q == ETC_WAIT_FRAME && state_d == ETC_EXPOSE; // R18
  wire frame_end   = state_q == ETC_READOUT && tick_end;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ETC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one software acquisition-start command is held until the stage consumes it or run is cleared
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_acq_q <= 1'b0;
    end else if (soft_acq_hit) begin
      soft_acq_q <= 1'b1;
    end else if (state_q == ETC_WAIT_ACQ || !run) begin
      soft_acq_q <= 1'b0;
    end
  end

  // exposure and readout share one down counter
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_q <= '0;
    end else if (frame_start) begin
      tick_q <= expo_cyc; // R20
    end else if (state_q == ETC_EXPOSE && tick_end) begin
      tick_q <= CNT_W'(READOUT_CYCLES);
    end else if (tick_q != '0) begin
      tick_q <= tick_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pace_q <= '0;
    end else if (frame_start) begin
      pace_q <= CNT_W'(1); // R10
    end else if (pace_q != {CNT_W{1'b1}}) begin
      pace_q <= pace_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exposing_q    <= 1'b0;
      frame_valid_q <= 1'b0;
      wait_frame_q  <= 1'b0;
      frames_q      <= '0;
    end else begin
      exposing_q    <= state_d == ETC_EXPOSE;
      frame_valid_q <= frame_end; // R15
      wait_frame_q  <= state_d == ETC_WAIT_FRAME;
      if (frame_end)
        frames_q <= frames_q + 32'h00000001;
    end
  end

  // ------------------------------------------------------------ register read
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (addr_in)
      OFS_CTRL:   rd_mux = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
      OFS_MULT:   rd_mux = {{(DATA_W-MULT_W){1'b0}}, mult_q};
      OFS_STEP:   rd_mux = {{(DATA_W-STEP_W){1'b0}}, step_q};
      OFS_ABS:    rd_mux = abs_val; // R5
      OFS_PERIOD: rd_mux = period_q;
      OFS_STATUS: rd_mux = {{(DATA_W-4){1'b0}}, div_wait_q, state_q};
      OFS_FRAMES: rd_mux = frames_q;
      default:    rd_mux = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_en_in ? rd_mux : '0;
    end
  end

  assign rd_data_out     = rd_data_q;
  assign exposing_out    = exposing_q;
  assign frame_valid_out = frame_valid_q;
  assign wait_frame_out  = wait_frame_q;

endmodule // etc_top

// file: design/etc_pkg.sv
package etc_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned READOUT_US    = 10;
  localparam int unsigned READOUT_CYC   = (READOUT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // field widths
  localparam int unsigned MULT_W  = 12;
  localparam int unsigned STEP_W  = 20;
  localparam int unsigned ABS_W   = 32;
  localparam int unsigned CNT_W   = 40;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;

  localparam logic [MULT_W-1:0] MULT_MIN = 12'h001;
  localparam logic [MULT_W-1:0] MULT_MAX = 12'hFFF;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MULT      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STEP      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ABS       = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SOFT_TRIG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FRAMES    = 8'h1C;

  // control register bits
  localparam int unsigned CTRL_LEGACY   = 0;
  localparam int unsigned CTRL_ACQ_ON   = 1;
  localparam int unsigned CTRL_FRAME_ON = 2;
  localparam int unsigned CTRL_RATE_EN  = 3;
  localparam int unsigned CTRL_FALLING  = 4;
  localparam int unsigned CTRL_RUN      = 5;
  localparam int unsigned CTRL_ORIGIN   = 6;
  localparam int unsigned CTRL_W        = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h01;

  // soft trigger bits
  localparam int unsigned SOFT_ACQ   = 0;
  localparam int unsigned SOFT_FRAME = 1;

  // status bits
  localparam int unsigned STAT_BUSY = 3;

  localparam logic [MULT_W-1:0] MULT_RST   = 12'h064;
  localparam logic [STEP_W-1:0] STEP_RST   = 20'h00014;
  localparam logic [DATA_W-1:0] PERIOD_RST = 32'h00008235;

  typedef enum logic [2:0] {
    ETC_IDLE,
    ETC_WAIT_ACQ,
    ETC_WAIT_FRAME,
    ETC_EXPOSE,
    ETC_READOUT
  } etc_state_t;

endpackage

// file: design/etc_div_if.sv
`timescale 1ns/1ps
interface etc_div_if;
  import etc_pkg::*;
  logic              start;
  logic [ABS_W-1:0]  dividend;
  logic [STEP_W-1:0] divisor;
  logic              busy;
  logic              done;
  logic [MULT_W-1:0] mult;

  modport client (output start, output dividend, output divisor, input busy, input done, input mult);
  modport server (input start, input dividend, input divisor, output busy, output done, output mult);
endinterface // etc_div_if

// file: design/etc_expo_div.sv
`timescale 1ns/1ps
module etc_expo_div
  import etc_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  etc_div_if.server div
);

  logic [STEP_W:0]   rem_q;
  logic [ABS_W-1:0]  quot_q;
  logic [5:0]        cnt_q;
  logic              busy_q;
  logic              done_q;
  logic [MULT_W-1:0] mult_q;

  wire  [STEP_W:0]   trial   = {rem_q[STEP_W-1:0], quot_q[ABS_W-1]};
  wire               fits    = trial >= {1'b0, div.divisor};
  wire  [STEP_W:0]   rem_nx  = fits ? trial - {1'b0, div.divisor} : trial;
  // round to nearest: half a step or more rounds up
  wire               round_up = {rem_q, 1'b0} >= {2'b00, div.divisor};
  wire  [ABS_W:0]    rounded  = {1'b0, quot_q} + {{ABS_W{1'b0}}, round_up};
  wire               too_big  = |rounded[ABS_W:MULT_W];
  wire               too_small = rounded[MULT_W-1:0] < MULT_MIN;
  wire  [MULT_W-1:0] clamped  = too_big ? MULT_MAX : (too_small ? MULT_MIN : rounded[MULT_W-1:0]);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rem_q  <= '0;
      quot_q <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      mult_q <= MULT_RST;
    end else begin
      done_q <= 1'b0;
      if (div.start) begin
        // a new request aborts any division still running
        rem_q  <= '0;
        quot_q <= div.dividend;
        cnt_q  <= 6'(ABS_W);
        busy_q <= 1'b1;
      end else if (busy_q && cnt_q != 6'h00) begin
        rem_q  <= rem_nx;
        quot_q <= {quot_q[ABS_W-2:0], fits};
        cnt_q  <= cnt_q - 6'h01;
      end else if (busy_q) begin
        mult_q <= clamped;
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign div.busy = busy_q;
  assign div.done = done_q;
  assign div.mult = mult_q;

endmodule // etc_expo_div

// file: verif/etc_sensor.sv
`timescale 1ns/1ps
module etc_sensor (
  input  wire logic clock_in,
  input  wire logic fire_in,
  output logic      pin_out
);
  int unsigned hold_q = 0;
  initial pin_out = 1'b0;
  // held six cycles so the three sync flops see it; a repeat fire only stretches it
  always @(posedge clock_in) begin
    if (fire_in) begin
      pin_out <= 1'b1;
      hold_q <= 6;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
      if (hold_q == 1) pin_out <= 1'b0;
    end
  end
endmodule // etc_sensor

// file: verif/etc_top_sva.sv
`timescale 1ns/1ps
module etc_top_sva
  import etc_pkg::*;
#(
  parameter int unsigned READOUT_CYCLES = READOUT_CYC
) (
  input wire logic              clock_in,
  input wire logic              resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic              wr_en_in,
  input wire logic              rd_en_in,
  input wire logic [DATA_W-1:0] rd_data_out,
  input wire logic              trig_pin_in,
  input wire logic              exposing_out,
  input wire logic              frame_valid_out,
  input wire logic              wait_frame_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       idle_q;
  wire pin_mode = ctrl_q[CTRL_FRAME_ON] && !ctrl_q[CTRL_ORIGIN] && !ctrl_q[CTRL_FALLING];
  wire fast_run = ctrl_q[CTRL_RUN] && !ctrl_q[CTRL_FRAME_ON] && !ctrl_q[CTRL_RATE_EN]
                  && (ctrl_q[CTRL_LEGACY] || !ctrl_q[CTRL_ACQ_ON]);
  // shadow of the control word, so the mode-dependent properties know the mode
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= CTRL_RST;
      idle_q <= '0;
    end else begin
      if (wr_en_in && addr_in == OFS_CTRL) ctrl_q <= wr_data_in[CTRL_W-1:0];
      idle_q <= exposing_out ? 16'h0000 : idle_q + 16'h0001;
    end
  end
  rd_quiet_a: assert property (!$past(rd_en_in) |-> rd_data_out == '0)
    else $error("read data not zero outside a read");
  pin_start_a: assert property (pin_mode && wait_frame_out && $rose(trig_pin_in) |-> ##[2:6] exposing_out)
    else $error("rising pin edge did not start exposure");
  no_trig_a: assert property ((pin_mode && wait_frame_out && $stable(trig_pin_in) && !wr_en_in) [*6] |=> !exposing_out)
    else $error("exposure without a trigger");
  start_wait_a: assert property (pin_mode && $rose(exposing_out) |-> $past(wait_frame_out))
    else $error("exposure began outside the wait state");
  wait_excl_a: assert property (!(exposing_out && wait_frame_out))
    else $error("waiting while exposing");
  expo_min_a: assert property ($rose(exposing_out) |=> exposing_out [*8])
    else $error("exposure cut short");
  frame_pulse_a: assert property (frame_valid_out |=> !frame_valid_out)
    else $error("frame pulse longer than one cycle");
  readout_len_a: assert property (frame_valid_out |-> idle_q >= READOUT_CYCLES - 1 && idle_q <= READOUT_CYCLES + 2)
    else $error("frame forwarded at wrong readout distance");
  free_next_a: assert property (fast_run && frame_valid_out |-> ##[1:6] exposing_out)
    else $error("free run did not restart at once");
  cover property ($rose(exposing_out));
  cover property (frame_valid_out);
  cover property (pin_mode && wait_frame_out && $rose(trig_pin_in));
endmodule // etc_top_sva

// file: verif/tb_exposure_trigger_control.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_exposure_trigger_control;
  import etc_pkg::*;
  localparam int unsigned RDO = 4;
  localparam int unsigned LO  = CYC_PER_US + RDO;
  logic              clock_in        = 1'b0;
  logic              resetn_in       = 1'b0;
  logic [ADDR_W-1:0] addr_in         = '0;
  logic [DATA_W-1:0] wr_data_in      = '0;
  logic              wr_en_in        = 1'b0;
  logic              rd_en_in        = 1'b0;
  logic              fire            = 1'b0;
  logic [DATA_W-1:0] rd_data_out;
  logic              trig_pin_in;
  logic              exposing_out;
  logic              frame_valid_out;
  logic              wait_frame_out;
  logic [DATA_W-1:0] v;
  int                n;
  int                n_mismatch      = 0;
  int                total_checks    = 0;

  always #5 clock_in = ~clock_in;

  etc_top #(.READOUT_CYCLES(RDO)) etc_top_inst (.clock_in, .resetn_in, .addr_in, .wr_data_in, .wr_en_in,
    .rd_en_in, .rd_data_out, .trig_pin_in, .exposing_out, .frame_valid_out, .wait_frame_out);
  etc_sensor etc_sensor_inst (.clock_in(clock_in), .fire_in(fire), .pin_out(trig_pin_in));

  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    v = rd_data_out;
  endtask
  task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  task automatic pulse();
    @(posedge clock_in);
    fire <= 1'b1;
    @(posedge clock_in);
    fire <= 1'b0;
  endtask
  // cycles from one exposure start to the next
  task automatic rise(output int c);
    c = 0;
    while (exposing_out === 1'b1 && c < 2000) begin tick(); c++; end
    while (exposing_out !== 1'b1 && c < 2000) begin tick(); c++; end
  endtask
  task automatic abs_set(input logic [DATA_W-1:0] a);
    wr(OFS_ABS, a);
    v = '1;
    for (int i = 0; i < 40 && v[STAT_BUSY] !== 1'b0; i++) rd(OFS_STATUS);
    `CHK(v[STAT_BUSY], 1'b0)
  endtask

  task automatic t_regs();
    chk(OFS_CTRL, 32'(CTRL_RST));
    chk(OFS_ABS, 32'(MULT_RST) * 32'(STEP_RST));
    chk(8'h20, 32'h0000_0000);
    wr(OFS_MULT, 32'h0000_0003);
    chk(OFS_ABS, 32'h0000_003C);
    wr(OFS_STEP, 32'h0000_003E);
    chk(OFS_ABS, 32'h0000_00BA);
    wr(OFS_MULT, 32'h0000_0000);
    chk(OFS_MULT, 32'h0000_0003);
    wr(OFS_MULT, 32'h0000_1000);
    chk(OFS_MULT, 32'h0000_0003);
    wr(OFS_MULT, 32'(MULT_MAX));
    chk(OFS_MULT, 32'(MULT_MAX));
  endtask
  task automatic t_abs();
    abs_set(32'h0000_007C);
    chk(OFS_MULT, 32'h0000_0002);
    chk(OFS_ABS, 32'h0000_007C);
    abs_set(32'h0000_0096);
    chk(OFS_ABS, 32'h0000_007C);
    abs_set(32'h0000_00A0);
    chk(OFS_ABS, 32'h0000_00BA);
  endtask
  task automatic t_pin();
    wr(OFS_STEP, 32'h0000_0001);
    wr(OFS_MULT, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0024);
    for (int i = 0; i < 60 && wait_frame_out !== 1'b1; i++) tick();
    `CHK(wait_frame_out, 1'b1)
    repeat (20) tick();
    `CHK(exposing_out, 1'b0)
    pulse();
    for (int i = 0; i < 10 && exposing_out !== 1'b1; i++) tick();
    `CHK(exposing_out, 1'b1)
    n = 0;
    // second edge mid-exposure must leave no trace
    while (exposing_out === 1'b1 && n < 500) begin
      tick();
      n++;
      fire <= (n == 30);
    end
    `CHK(n, CYC_PER_US)
    for (int i = 0; i < 20 && frame_valid_out !== 1'b1; i++) tick();
    `CHK(frame_valid_out, 1'b1)
    repeat (30) tick();
    `CHK(exposing_out, 1'b0)
    chk(OFS_FRAMES, 32'h0000_0001);
  endtask
  task automatic t_legacy();
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0027);
    for (int i = 0; i < 60 && wait_frame_out !== 1'b1; i++) tick();
    `CHK(wait_frame_out, 1'b1)
    pulse();
    for (int i = 0; i < 10 && exposing_out !== 1'b1; i++) tick();
    `CHK(exposing_out, 1'b1)
    for (int i = 0; i < 300 && frame_valid_out !== 1'b1; i++) tick();
    `CHK(frame_valid_out, 1'b1)
  endtask
  task automatic t_modes();
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0066);
    repeat (20) tick();
    `CHK(wait_frame_out, 1'b0)
    wr(OFS_SOFT_TRIG, 32'h0000_0001);
    for (int i = 0; i < 10 && wait_frame_out !== 1'b1; i++) tick();
    `CHK(wait_frame_out, 1'b1)
    wr(OFS_SOFT_TRIG, 32'h0000_0002);
    for (int i = 0; i < 10 && exposing_out !== 1'b1; i++) tick();
    `CHK(exposing_out, 1'b1)
    for (int i = 0; i < 300 && wait_frame_out !== 1'b1; i++) tick();
    wr(OFS_CTRL, 32'h0000_0034);
    pulse();
    repeat (5) tick();
    `CHK(exposing_out, 1'b0)
    for (int i = 0; i < 10 && exposing_out !== 1'b1; i++) tick();
    `CHK(exposing_out, 1'b1)
    // reset in mid-exposure must drop the frame and restore legacy mode
    repeat (10) tick();
    resetn_in <= 1'b0;
    repeat (3) tick();
    `CHK(exposing_out, 1'b0)
    resetn_in <= 1'b1;
    chk(OFS_CTRL, 32'(CTRL_RST));
    wr(OFS_STEP, 32'h0000_0001);
    wr(OFS_MULT, 32'h0000_0001);
  endtask
  task automatic t_free();
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0020);
    repeat (3) rise(n);
    `CHK(n >= LO && n <= LO + 6, 1'b1)
    wr(OFS_PERIOD, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0028);
    repeat (3) rise(n);
    `CHK(n >= 3 * CYC_PER_US - 1 && n <= 3 * CYC_PER_US + 1, 1'b1)
    wr(OFS_PERIOD, 32'h0000_0001);
    repeat (3) rise(n);
    `CHK(n >= LO && n <= LO + 6, 1'b1)
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_regs();
    t_abs();
    t_pin();
    t_legacy();
    t_modes();
    t_free();
    wrap_up();
  end
  // whole run needs a few thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    wrap_up();
  end
endmodule // tb_exposure_trigger_control

bind etc_top etc_top_sva #(.READOUT_CYCLES(READOUT_CYCLES)) etc_top_sva_inst (.clock_in, .resetn_in, .addr_in,
  .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .trig_pin_in, .exposing_out, .frame_valid_out, .wait_frame_out);
